/* File: core/mipr_resolver.sv */
// Maskable interrupt acceptance and priority resolver
// Function
// - Key pin falling edge sets key request
// - Key edge counts only if others high
// - Per-source control; enable and level in flags
// - Non-maskable interrupts bypass enable and levels
// - Enable flag gates all maskable; resets clear
// - Return applies enable now; others next instruction
// - Hardware sets, acceptance clears; software clears only
// - Level 0 disables, 1 lowest, 7 highest
// - Accept: enable, request, level above processor level
// - Processor level n passes levels above n
// - Enable, requests, levels, processor level independent
// - Return-restored level gates after 2 cycles
// - Pop/load level change gates after 3 cycles
// - Source level write gates after 2 cycles
// - Highest level wins; ties by hardware order
// - Fixed order nmi, debug, watchdog, software, peripheral, step, match
// - Software interrupts ungated; lose only to nmi, debug, watchdog
// - Acceptance clears enable, request; loads level
// - Rejected requests stay pending until level allows
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mipr_regs.svh"
module mipr_resolver #(
	parameter int NUM_SRC = 8,
	parameter int KEY_PINS = 8,
	parameter int SRC_W = $clog2(NUM_SRC)
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [KEY_PINS-1:0] key_pin_n,
	input wire logic [NUM_SRC-1:1] periph_req,
	input wire logic nmi_req,
	input wire logic debug_request,
	input wire logic wdog_req,
	input wire logic step_req,
	input wire logic amatch_req,
	input wire logic swi_req,
	input wire logic sample_req,
	input wire logic flag_wr,
	input wire mipr_pkg::mipr_flag_kind_type flag_kind,
	input wire logic gie_wr_en,
	input wire logic gie_val,
	input wire logic ipl_wr_en,
	input wire logic [2:0] ipl_val,
	output logic accept_valid,
	output mipr_pkg::mipr_accept_kind_type accept_kind,
	output logic [SRC_W-1:0] accept_src,
	output logic [2:0] accept_level,
	output logic gie_out,
	output logic [2:0] processor_priority_level
);
	localparam int LVL_STAGES = `MIPR_LVL_DLY - 1;

	// Key pins: two synchroniser stages plus one history stage
	logic [KEY_PINS-1:0] key_s1_q;
	logic [KEY_PINS-1:0] key_s2_q;
	logic [KEY_PINS-1:0] key_s3_q;
	logic key_evt;

	logic gie_q;
	logic [2:0] ipl_q;
	logic [2:0] ipl_gate_q;
	logic [2:0] ipl_pend_q;
	logic [1:0] ipl_cnt_q;
	logic [NUM_SRC-1:0] req_q;
	logic [NUM_SRC-1:0] req_set;
	logic [NUM_SRC-1:0] req_clr;
	logic [2:0] lvl_q [NUM_SRC];
	logic [2:0] lvl_pipe_q [NUM_SRC][LVL_STAGES];
	mipr_pkg::mipr_state_type st_q;
	logic [7:0] rdata_q;
	logic accept_valid_q;
	mipr_pkg::mipr_accept_kind_type accept_kind_q;
	logic [SRC_W-1:0] accept_src_q;
	logic [2:0] accept_level_q;

	logic wr_flag;
	logic wr_src;
	logic [SRC_W-1:0] wr_idx;
	logic gie_eff;
	logic [2:0] best_lvl;
	logic [SRC_W-1:0] best_idx;
	logic best_hit;
	logic mask_ok;
	mipr_pkg::mipr_accept_kind_type win_kind;
	logic grant;
	logic grant_periph;
	logic [7:0] rd_val;

	// Source register address decode
	function automatic logic src_hit(input logic [7:0] addr);
		logic [8:0] top;
		top = {1'b0, `MIPR_SRC_BASE} + 9'(NUM_SRC);
		src_hit = (addr >= `MIPR_SRC_BASE) && ({1'b0, addr} < top);
	endfunction

	function automatic logic [SRC_W-1:0] src_idx(input logic [7:0] addr);
		logic [7:0] off;
		off = addr - `MIPR_SRC_BASE;
		src_idx = off[SRC_W-1:0];
	endfunction

	// Single falling edge while every other key pin is high in the same sample
	function automatic logic key_edge_ok(input logic [KEY_PINS-1:0] prev,
			input logic [KEY_PINS-1:0] cur);
		logic ok;
		logic [KEY_PINS-1:0] mask;
		ok = 1'b0;
		for (int i = 0; i < KEY_PINS; i++) begin
			mask = '0;
			mask[i] = 1'b1;
			if (prev[i] && !cur[i] && ((cur | mask) == '1)) begin
				ok = 1'b1;
			end
		end
		key_edge_ok = ok;
	endfunction

	// Key synchroniser and edge history
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			key_s1_q <= {KEY_PINS{`MIPR_KEY_RST}};
			key_s2_q <= {KEY_PINS{`MIPR_KEY_RST}};
			key_s3_q <= {KEY_PINS{`MIPR_KEY_RST}};
		end else begin
			key_s1_q <= key_pin_n;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
		end
	end

	assign key_evt = key_edge_ok(key_s3_q, key_s2_q);

	// Register write decode
	assign wr_flag = reg_wr && (reg_addr == `MIPR_FLAG_ADDR);
	assign wr_src = reg_wr && src_hit(reg_addr);
	assign wr_idx = src_idx(reg_addr);

	// Return instruction changes enable within its own sampling
	always_comb begin
		if (flag_wr && gie_wr_en && flag_kind == mipr_pkg::FK_RETURN_FROM_INTERRUPT_INSTR) begin
			gie_eff = gie_val;
		end else begin
			gie_eff = gie_q;
		end
	end

	// Highest level, lower index wins ties
	always_comb begin
		best_lvl = 3'h0;
		best_idx = '0;
		best_hit = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (req_q[i] && lvl_pipe_q[i][LVL_STAGES-1] > best_lvl) begin
				best_lvl = lvl_pipe_q[i][LVL_STAGES-1];
				best_idx = SRC_W'(i);
				best_hit = 1'b1;
			end
		end
	end

	always_comb begin
		mask_ok = 1'b0;
		if (best_hit && gie_eff) begin
			mask_ok = (best_lvl > ipl_gate_q);
		end
	end

	// Fixed order of special and software interrupts
	always_comb begin
		if (nmi_req) begin
			win_kind = mipr_pkg::AK_NMI;
		end else if (debug_request) begin
			win_kind = mipr_pkg::AK_DEBUG;
		end else if (wdog_req) begin
			win_kind = mipr_pkg::AK_WDOG;
		end else if (swi_req) begin
			win_kind = mipr_pkg::AK_SWI;
		end else if (mask_ok) begin
			win_kind = mipr_pkg::AK_PERIPH;
		end else if (step_req) begin
			win_kind = mipr_pkg::AK_STEP;
		end else if (amatch_req) begin
			win_kind = mipr_pkg::AK_AMATCH;
		end else begin
			win_kind = mipr_pkg::AK_NONE;
		end
	end

	// Grant when sampled idle and a winner exists
	assign grant = sample_req && (st_q == mipr_pkg::ST_IDLE) && (win_kind != mipr_pkg::AK_NONE);
	assign grant_periph = grant && (win_kind == mipr_pkg::AK_PERIPH);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= mipr_pkg::ST_IDLE;
		end else begin
			case (st_q)
				mipr_pkg::ST_IDLE: begin
					if (grant) begin
						st_q <= mipr_pkg::ST_GRANT;
					end
				end
				mipr_pkg::ST_GRANT: begin
					st_q <= mipr_pkg::ST_IDLE;
				end
				default: begin
					st_q <= mipr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Acceptance report, valid one cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			accept_valid_q <= 1'b0;
			accept_kind_q <= mipr_pkg::AK_NONE;
			accept_src_q <= '0;
			accept_level_q <= 3'h0;
		end else begin
			accept_valid_q <= grant;
			if (grant) begin
				accept_kind_q <= win_kind;
				accept_src_q <= '0;
				accept_level_q <= 3'h0;
			end
			if (grant_periph) begin
				accept_src_q <= best_idx;
				accept_level_q <= best_lvl;
			end
		end
	end

	// Global enable flag
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gie_q <= `MIPR_GIE_RST;
		end else if (grant) begin
			gie_q <= 1'b0;
		end else if (flag_wr && gie_wr_en) begin
			gie_q <= gie_val;
		end else if (wr_flag) begin
			gie_q <= reg_wdata[`MIPR_GIE_BIT];
		end
	end

	// Stored processor level
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ipl_q <= `MIPR_IPL_RST;
		end else if (grant_periph) begin
			ipl_q <= best_lvl;
		end else if (flag_wr && ipl_wr_en) begin
			ipl_q <= ipl_val;
		end else if (wr_flag) begin
			ipl_q <= reg_wdata[`MIPR_IPL_LSB+:3];
		end
	end

	// Delayed processor level used for gating
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ipl_gate_q <= `MIPR_IPL_RST;
			ipl_pend_q <= `MIPR_IPL_RST;
			ipl_cnt_q <= 2'h0;
		end else if (grant_periph) begin
			ipl_gate_q <= best_lvl;
			ipl_cnt_q <= 2'h0;
		end else if (flag_wr && ipl_wr_en) begin
			ipl_pend_q <= ipl_val;
			if (flag_kind == mipr_pkg::FK_RETURN_FROM_INTERRUPT_INSTR) begin
				ipl_cnt_q <= 2'(`MIPR_IPL_RETURN_FROM_INTERRUPT_INSTR_DLY - 1);
			end else begin
				ipl_cnt_q <= 2'(`MIPR_IPL_CTRL_DLY - 1);
			end
		end else if (wr_flag) begin
			ipl_pend_q <= reg_wdata[`MIPR_IPL_LSB+:3];
			ipl_cnt_q <= 2'(`MIPR_IPL_CTRL_DLY - 1);
		end else if (ipl_cnt_q != 2'h0) begin
			ipl_cnt_q <= ipl_cnt_q - 2'h1;
			if (ipl_cnt_q == 2'h1) begin
				ipl_gate_q <= ipl_pend_q;
			end
		end
	end

	// Request bits: a set beats a clear in the same cycle
	assign req_set = {periph_req, key_evt};
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			req_clr[i] = (wr_src && wr_idx == SRC_W'(i) && !reg_wdata[`MIPR_REQ_BIT])
				|| (grant_periph && best_idx == SRC_W'(i));
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_q <= '0;
		end else begin
			req_q <= (req_q & ~req_clr) | req_set;
		end
	end

	// Source levels and their gating delay
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				lvl_q[i] <= `MIPR_LVL_RST;
			end
		end else if (wr_src) begin
			lvl_q[wr_idx] <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				for (int s = 0; s < LVL_STAGES; s++) begin
					lvl_pipe_q[i][s] <= `MIPR_LVL_RST;
				end
			end
		end else begin
			for (int i = 0; i < NUM_SRC; i++) begin
				lvl_pipe_q[i][0] <= lvl_q[i];
				for (int s = 1; s < LVL_STAGES; s++) begin
					lvl_pipe_q[i][s] <= lvl_pipe_q[i][s-1];
				end
			end
		end
	end

	// Register read decode
	always_comb begin
		rd_val = 8'h00;
		if (reg_addr == `MIPR_FLAG_ADDR) begin
			rd_val[`MIPR_GIE_BIT] = gie_q;
			rd_val[`MIPR_IPL_LSB+:3] = ipl_q;
		end else if (reg_addr == `MIPR_STAT_ADDR) begin
			rd_val[`MIPR_STAT_ANY_BIT] = |req_q;
			rd_val[`MIPR_STAT_OK_BIT] = mask_ok;
			rd_val[`MIPR_IPL_LSB+:3] = ipl_gate_q;
		end else if (src_hit(reg_addr)) begin
			rd_val[2:0] = lvl_q[src_idx(reg_addr)];
			rd_val[`MIPR_REQ_BIT] = req_q[src_idx(reg_addr)];
		end
	end

	// Read data stands one cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= rd_val;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign accept_valid = accept_valid_q;
	assign accept_kind = accept_kind_q;
	assign accept_src = accept_src_q;
	assign accept_level = accept_level_q;
	assign gie_out = gie_q;
	assign processor_priority_level = ipl_q;
endmodule // mipr_resolver

/* File: core/mipr_regs.svh */
// Register offsets, field positions, reset values and delay counts of the resolver
`ifndef MIPR_REGS_SVH
`define MIPR_REGS_SVH
`define MIPR_FLAG_ADDR 8'h00
`define MIPR_STAT_ADDR 8'h04
`define MIPR_SRC_BASE 8'h10
`define MIPR_GIE_BIT 0
`define MIPR_IPL_LSB 4
`define MIPR_REQ_BIT 3
`define MIPR_STAT_ANY_BIT 0
`define MIPR_STAT_OK_BIT 1
`define MIPR_GIE_RST 1'b0
`define MIPR_IPL_RST 3'h0
`define MIPR_LVL_RST 3'h0
`define MIPR_KEY_RST 1'b1
`define MIPR_IPL_RETURN_FROM_INTERRUPT_INSTR_DLY 2
`define MIPR_IPL_CTRL_DLY 3
`define MIPR_LVL_DLY 2
`endif

/* File: core/mipr_pkg.sv */
// Types shared by the interrupt priority resolver
package mipr_pkg;
	typedef enum logic [1:0] {
		FK_RETURN_FROM_INTERRUPT_INSTR = 2'h0,
		FK_FLAG = 2'h1,
		FK_CTRL = 2'h2,
		FK_LOAD_PRIORITY_INSTR = 2'h3
	} mipr_flag_kind_type;
	typedef enum logic [2:0] {
		AK_NONE = 3'h0,
		AK_NMI = 3'h1,
		AK_DEBUG = 3'h2,
		AK_WDOG = 3'h3,
		AK_SWI = 3'h4,
		AK_PERIPH = 3'h5,
		AK_STEP = 3'h6,
		AK_AMATCH = 3'h7
	} mipr_accept_kind_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_GRANT = 2'b01
	} mipr_state_type;
endpackage

/* File: sim/mipr_resolver_properties.sv */
// Port checks of the interrupt priority resolver
`timescale 1ns/1ps
module mipr_resolver_properties #(
	parameter int NUM_SRC = 8,
	parameter int KEY_PINS = 8,
	parameter int SRC_W = $clog2(NUM_SRC)
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [KEY_PINS-1:0] key_pin_n,
	input wire logic [NUM_SRC-1:1] periph_req,
	input wire logic nmi_req,
	input wire logic debug_request,
	input wire logic wdog_req,
	input wire logic step_req,
	input wire logic amatch_req,
	input wire logic swi_req,
	input wire logic sample_req,
	input wire logic flag_wr,
	input wire mipr_pkg::mipr_flag_kind_type flag_kind,
	input wire logic gie_wr_en,
	input wire logic gie_val,
	input wire logic ipl_wr_en,
	input wire logic [2:0] ipl_val,
	input wire logic accept_valid,
	input wire mipr_pkg::mipr_accept_kind_type accept_kind,
	input wire logic [SRC_W-1:0] accept_src,
	input wire logic [2:0] accept_level,
	input wire logic gie_out,
	input wire logic [2:0] processor_priority_level
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence grant_s;
		accept_valid;
	endsequence
	sequence periph_s;
		accept_valid && accept_kind == mipr_pkg::AK_PERIPH;
	endsequence
	pulse_once_a: assert property (grant_s |=> !accept_valid)
		else $error("accept held two cycles");
	sample_cause_a: assert property (grant_s |-> $past(sample_req))
		else $error("accept without sample");
	grant_clears_a: assert property (grant_s |-> !gie_out)
		else $error("enable kept on grant");
	level_load_a: assert property (periph_s |-> processor_priority_level == accept_level)
		else $error("level not loaded");
	nonzero_level_a: assert property (periph_s |-> accept_level != 3'h0)
		else $error("level zero accepted");
	enable_gate_a: assert property (periph_s |-> $past(gie_out) || ($past(flag_wr)
		&& $past(gie_val) && $past(gie_wr_en) && $past(flag_kind) == mipr_pkg::FK_RETURN_FROM_INTERRUPT_INSTR))
		else $error("maskable taken while disabled");
	nmi_first_a: assert property (sample_req && nmi_req && !accept_valid
		|=> accept_valid && accept_kind == mipr_pkg::AK_NMI)
		else $error("nmi not taken");
	swi_taken_a: assert property (sample_req && swi_req && !nmi_req && !debug_request
		&& !wdog_req && !accept_valid |=> accept_valid && accept_kind == mipr_pkg::AK_SWI)
		else $error("software interrupt not taken");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read");
endmodule // mipr_resolver_properties

/* File: sim/mipr_key_pad.sv */
// Key pad model driving the key pins
`timescale 1ns/1ps
module mipr_key_pad #(
	parameter int KEY_PINS = 8
) (
	input wire logic [KEY_PINS-1:0] key_press,
	output logic [KEY_PINS-1:0] key_pin_n
);
	// Pull-ups hold released pins high
	assign key_pin_n = ~key_press;
endmodule // mipr_key_pad

/* File: sim/maskable_interrupt_priority_resolver_test.sv */
// Self-checking bench of the interrupt priority resolver
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	$display("ERROR %s exp %0h got %0h", n, e, g); err_total++; end end
module maskable_interrupt_priority_resolver_test;
	logic core_clk, reset_n, reg_wr, reg_rd, nmi_req, debug_request, wdog_req, step_req;
	logic amatch_req, swi_req, sample_req, flag_wr, gie_wr_en, gie_val, ipl_wr_en;
	logic accept_valid, gie_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, key_press, key_pin_n;
	logic [7:1] periph_req;
	logic [2:0] ipl_val, accept_level, processor_priority_level, accept_src;
	mipr_pkg::mipr_flag_kind_type flag_kind;
	mipr_pkg::mipr_accept_kind_type accept_kind;
	mipr_pkg::mipr_accept_kind_type kinds [6] = '{mipr_pkg::AK_NMI, mipr_pkg::AK_DEBUG,
		mipr_pkg::AK_WDOG, mipr_pkg::AK_SWI, mipr_pkg::AK_STEP, mipr_pkg::AK_AMATCH};
	int err_total = 0;
	int checks_done = 0;
	mipr_key_pad #(.KEY_PINS(8)) pad (.key_press, .key_pin_n);
	mipr_resolver dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .key_pin_n, .periph_req, .nmi_req, .debug_request, .wdog_req,
		.step_req, .amatch_req, .swi_req, .sample_req, .flag_wr, .flag_kind, .gie_wr_en,
		.gie_val, .ipl_wr_en, .ipl_val, .accept_valid, .accept_kind, .accept_src,
		.accept_level, .gie_out, .processor_priority_level);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task conclude;
		if (err_total == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata)
	endtask
	task samp(input logic v, input mipr_pkg::mipr_accept_kind_type k, input logic [2:0] s,
		input logic [2:0] l);
		sample_req <= 1'b1;
		@(posedge core_clk);
		sample_req <= 1'b0;
		#1;
		`CHK("valid", v, accept_valid)
		if (v) begin
			`CHK("kind", k, accept_kind)
			`CHK("src", s, accept_src)
			`CHK("level", l, accept_level)
		end
	endtask
	task none;
		samp(1'b0, mipr_pkg::AK_NONE, 3'h0, 3'h0);
	endtask
	task fw(input mipr_pkg::mipr_flag_kind_type k, input logic [2:0] ip, input logic s);
		flag_wr <= 1'b1;
		flag_kind <= k;
		ipl_val <= ip;
		sample_req <= s;
		@(posedge core_clk);
		flag_wr <= 1'b0;
		sample_req <= 1'b0;
		#1;
	endtask
	task pr(input logic [7:1] m);
		periph_req <= m;
		@(posedge core_clk);
		periph_req <= 7'h00;
		#1;
	endtask
	initial begin
		#20000;
		err_total++;
		conclude;
	end
	initial begin
		{reset_n, reg_wr, reg_rd, nmi_req, debug_request, wdog_req, step_req} = 7'h00;
		{amatch_req, swi_req, sample_req, flag_wr, ipl_val} = 7'h00;
		{gie_wr_en, gie_val, ipl_wr_en} = 3'h7;
		{reg_addr, reg_wdata, key_press, periph_req} = 31'h0;
		flag_kind = mipr_pkg::FK_RETURN_FROM_INTERRUPT_INSTR;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		rd(8'h00, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'h11, 8'h05);
		wr(8'h12, 8'h05);
		wr(8'h13, 8'h03);
		pr(7'h07);
		none;
		wr(8'h00, 8'h21);
		idle(3);
		rd(8'h11, 8'h0D);
		samp(1'b1, mipr_pkg::AK_PERIPH, 3'h1, 3'h5);
		`CHK("ipl", 3'h5, processor_priority_level)
		rd(8'h11, 8'h05);
		rd(8'h12, 8'h0D);
		wr(8'h14, 8'h0C);
		rd(8'h14, 8'h04);
		fw(mipr_pkg::FK_RETURN_FROM_INTERRUPT_INSTR, 3'h0, 1'b1);
		`CHK("same cycle", 1'b0, accept_valid)
		`CHK("gie", 1'b1, gie_out)
		`CHK("ipl", 3'h0, processor_priority_level)
		none;
		samp(1'b1, mipr_pkg::AK_PERIPH, 3'h2, 3'h5);
		fw(mipr_pkg::FK_CTRL, 3'h2, 1'b0);
		none;
		none;
		samp(1'b1, mipr_pkg::AK_PERIPH, 3'h3, 3'h3);
		wr(8'h00, 8'h01);
		idle(3);
		pr(7'h20);
		none;
		wr(8'h16, 8'h0E);
		none;
		samp(1'b1, mipr_pkg::AK_PERIPH, 3'h6, 3'h6);
		rd(8'h16, 8'h06);
		wr(8'h00, 8'h71);
		wr(8'h15, 8'h07);
		pr(7'h10);
		idle(3);
		none;
		rd(8'h04, 8'h71);
		for (int k = 0; k < 6; k++) begin
			{amatch_req, step_req, swi_req, wdog_req, debug_request, nmi_req} <= 6'h3F << k;
			idle(1);
			samp(1'b1, kinds[k], 3'h0, 3'h0);
		end
		`CHK("ipl", 3'h7, processor_priority_level)
		{amatch_req, step_req, swi_req, wdog_req, debug_request, nmi_req} <= 6'h00;
		key_press <= 8'h01;
		idle(6);
		rd(8'h10, 8'h08);
		key_press <= 8'h02;
		idle(6);
		wr(8'h10, 8'h00);
		key_press <= 8'h06;
		idle(6);
		rd(8'h10, 8'h00);
		conclude;
	end
endmodule // maskable_interrupt_priority_resolver_test
bind mipr_resolver mipr_resolver_properties #(.NUM_SRC(NUM_SRC), .KEY_PINS(KEY_PINS),
	.SRC_W(SRC_W)) chk (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .key_pin_n, .periph_req, .nmi_req, .debug_request, .wdog_req, .step_req,
	.amatch_req, .swi_req, .sample_req, .flag_wr, .flag_kind, .gie_wr_en, .gie_val,
	.ipl_wr_en, .ipl_val, .accept_valid, .accept_kind, .accept_src, .accept_level,
	.gie_out, .processor_priority_level);
